// >>> pkg/phy_regs_pkg.sv
// constants for the phy identification and advertisement register bank
package phy_regs_pkg;
   localparam int unsigned REG_W         = 16;
   localparam int unsigned IDX_W         = 8;
   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_ID_HIGH   = 8'h02;
   localparam logic [7:0]  IDX_ID_LOW    = 8'h03;
   localparam logic [7:0]  IDX_ADV       = 8'h04;
   localparam logic [7:0]  IDX_CTRL      = 8'h10;
   localparam logic [7:0]  IDX_STAT      = 8'h11;
   // identification low word fields
   localparam int unsigned ID_OUI_LSB    = 10;
   localparam int unsigned ID_OUI_W      = 6;
   localparam int unsigned ID_MODEL_LSB  = 4;
   localparam int unsigned ID_MODEL_W    = 6;
   localparam int unsigned ID_REV_LSB    = 0;
   localparam int unsigned ID_REV_W      = 4;
   // advertisement word fields
   localparam int unsigned ADV_RFAULT    = 13;
   localparam int unsigned ADV_RSVD12    = 12;
   localparam int unsigned ADV_ASYM      = 11;
   localparam int unsigned ADV_SYM       = 10;
   localparam int unsigned ADV_100FD     = 8;
   localparam int unsigned ADV_100HD     = 7;
   localparam int unsigned ADV_10FD      = 6;
   localparam int unsigned ADV_10HD      = 5;
   localparam int unsigned ADV_SEL_LSB   = 0;
   localparam logic [15:0] ADV_RW_MASK   = 16'h3DFF;
   localparam logic [15:0] ADV_RST       = 16'h0181;
   // control and status fields
   localparam int unsigned CTRL_RELOAD   = 0;
   localparam int unsigned STAT_BUSY     = 0;
   localparam int unsigned STAT_CAPT     = 1;
   localparam int unsigned STAT_STRAP    = 4;
   localparam logic [15:0] ZERO_WORD     = 16'h0000;
   // settle cycles of the strap synchroniser before the capture
   localparam logic [1:0]  STRAP_SETTLE  = 2'h2;
   // strap vector layout
   localparam int unsigned STRAP_AN      = 0;
   localparam int unsigned STRAP_SPEED   = 1;
   localparam int unsigned STRAP_DUPLEX  = 2;
   localparam int unsigned STRAP_MPAUSE  = 3;
   localparam int unsigned STRAP_W       = 4;
endpackage

// >>> pkg/adv_ctrl_if.sv
// internal carrier between register bank, strap capture and loader
`timescale 1ns/10ps
interface adv_ctrl_if;
   logic        strap_done;
   logic [3:0]  strap_val;
   logic        captured;
   logic        load_start;
   logic        load_busy;
   logic        load_valid;
   logic [15:0] load_data;
   modport strap_src (output strap_done, output strap_val,
                      output captured);
   modport loader    (input load_start, output load_busy,
                      output load_valid, output load_data);
   modport regs      (input strap_done, input strap_val, input captured,
                      output load_start, input load_busy,
                      input load_valid, input load_data);
endinterface

// >>> hdl/strap_capture.sv
// strap synchroniser and one-shot capture after reset release
`timescale 1ns/10ps
module strap_capture (
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic [phy_regs_pkg::STRAP_W-1:0] strap_pins,
   adv_ctrl_if.strap_src                    sc
);
   import phy_regs_pkg::*;

   logic [STRAP_W-1:0] sync1_q;
   logic [STRAP_W-1:0] sync2_q;
   logic [STRAP_W-1:0] val_q;
   logic [STRAP_W-1:0] val_d;
   logic [1:0]         cnt_q;
   logic [1:0]         cnt_d;
   logic               capt_q;
   logic               capt_d;
   logic               done_q;
   logic               done_d;

   // wait for the synchroniser to fill, then capture once and hold
   always_comb begin
      cnt_d  = cnt_q;
      capt_d = capt_q;
      val_d  = val_q;
      done_d = 1'b0;
      if (!capt_q) begin
         if (cnt_q == STRAP_SETTLE) begin
            val_d  = sync2_q;       // R15
            capt_d = 1'b1;
            done_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 2'h1;
         end
      end
   end

   // straps come from pins, so two flops before anything reads them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         val_q   <= '0;
         cnt_q   <= 2'h0;
         capt_q  <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         sync1_q <= strap_pins;
         sync2_q <= sync1_q;
         val_q   <= val_d;
         cnt_q   <= cnt_d;
         capt_q  <= capt_d;
         done_q  <= done_d;
      end
   end

   assign sc.strap_val  = val_q;
   assign sc.strap_done = done_q;
   assign sc.captured   = capt_q;
endmodule

// >>> hdl/adv_loader.sv
// loader that fetches the advertisement word from the eeprom side
`timescale 1ns/10ps
module adv_loader (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   output logic             ee_rd_req,
   input  wire logic        ee_rd_valid,
   input  wire logic [15:0] ee_rd_data,
   adv_ctrl_if.loader       lc
);
   import phy_regs_pkg::*;

   typedef enum logic [1:0] {
      LD_IDLE  = 2'b00,
      LD_FETCH = 2'b01
   } ld_state_t;

   ld_state_t   st_q;
   ld_state_t   st_d;
   logic        vld_q;
   logic        vld_d;
   logic [15:0] dat_q;
   logic [15:0] dat_d;

   // a start while a fetch runs is dropped; the running fetch serves it
   always_comb begin
      st_d  = st_q;
      vld_d = 1'b0;
      dat_d = dat_q;
      case (st_q)
         LD_IDLE: begin
            if (lc.load_start) begin
               st_d = LD_FETCH;
            end
         end
         LD_FETCH: begin
            if (ee_rd_valid) begin
               vld_d = 1'b1;        // R05
               dat_d = ee_rd_data;  // R10
               st_d  = LD_IDLE;
            end
         end
         default: begin
            st_d = LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q  <= LD_IDLE;
         vld_q <= 1'b0;
         dat_q <= ZERO_WORD;
      end else begin
         st_q  <= st_d;
         vld_q <= vld_d;
         dat_q <= dat_d;
      end
   end

   assign ee_rd_req     = (st_q == LD_FETCH);
   assign lc.load_busy  = (st_q == LD_FETCH) || vld_q;
   assign lc.load_valid = vld_q;
   assign lc.load_data  = dat_q;
endmodule

// >>> hdl/phy_id_autoneg_advert_regs.sv
// phy identification and auto-negotiation advertisement registers
//
// Overview of operation
// (R01) oui bits 19..24 in id low 15:10
// (R02) six-bit model number in id low 9:4
// (R03) four-bit revision number in id low 3:0
// (R04) id low at index 3, advert index 4
// (R05) loader rewrites advert after reset and reload
// (R06) bit 13 advertises remote fault, resets 0
// (R07) software writes zero to reserved bit 12
// (R08) bit 11 advertises asymmetric pause, resets 0
// (R09) bit 10 default is inverted manual pause strap
// (R10) loader supplies both pause advertisement bits
// (R11) bits 8 and 7 reset to one
// (R12) bit 6 default: an or (!speed and duplex)
// (R13) bit 5 default: an or not speed
// (R14) selector field 4:0 resets to 00001
// (R15) straps captured at reset release, then held
// (R16) id high at index 2 holds oui bits 3..18
// (R17) bits 15:14 and 9 read zero, ignore writes
`timescale 1ns/10ps
module phy_id_autoneg_advert_regs #(
   // identification values; all defaults arbitrary
   parameter logic [15:0] OUI_HIGH_ID = 16'h0123,
   parameter logic [5:0]  OUI_LOW_ID  = 6'h15,
   parameter logic [5:0]  MODEL_ID    = 6'h2A,
   parameter logic [3:0]  REV_ID      = 4'h3
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        autoneg_pin_cfg,
   input  wire logic        speed_pin_cfg,
   input  wire logic        duplex_pin_cfg,
   input  wire logic        manual_pause_pin_cfg,
   output logic             ee_rd_req,
   input  wire logic        ee_rd_valid,
   input  wire logic [15:0] ee_rd_data,
   output logic [15:0]      advert_word,
   output logic [15:0]      id_high_word,
   output logic [15:0]      id_low_word
);
   import phy_regs_pkg::*;

   adv_ctrl_if ac ();

   // strap pins gathered into one vector for the synchroniser
   logic [STRAP_W-1:0] strap_pins;
   // write pending from the address phase and its word index
   logic               wr_pend_q;
   logic               wr_pend_d;
   logic [7:0]         widx_q;
   logic [7:0]         widx_d;
   logic [8:0]         aidx;
   // register contents and their next values
   logic [15:0]        idh_q;
   logic [15:0]        idh_d;
   logic [15:0]        idl_q;
   logic [15:0]        idl_d;
   logic [15:0]        adv_q;
   logic [15:0]        adv_d;
   // read word held through the data phase
   logic [31:0]        rdata_q;
   logic [31:0]        rdata_d;
   // reload command and the loader start pulse
   logic               reload_d;
   logic               start_q;
   logic               start_d;
   // bus decode helpers
   logic               addr_take;
   logic [15:0]        wword;
   // status view and the latched strap levels
   logic [15:0]        stat_word;
   logic               an_s;
   logic               spd_s;
   logic               dup_s;
   logic               mp_s;

   // word index from a byte address; non-word addresses map nowhere
   function automatic logic [8:0] word_index(input logic [31:0] a);
      logic [8:0] r;
      r = 9'h100;
      if (a[1:0] == 2'b00 && a[31:10] == 22'h0) begin
         r = {1'b0, a[9:2]};
      end
      return r;
   endfunction

   // read value of a word index given the register contents
   function automatic logic [15:0] read_word(
      input logic [8:0]  i,
      input logic [15:0] h,
      input logic [15:0] l,
      input logic [15:0] v,
      input logic [15:0] s
   );
      logic [15:0] r;
      r = ZERO_WORD;
      if (i == {1'b0, IDX_ID_HIGH}) begin
         r = h;
      end else if (i == {1'b0, IDX_ID_LOW}) begin
         r = l;
      end else if (i == {1'b0, IDX_ADV}) begin
         r = v & ADV_RW_MASK;
      end else if (i == {1'b0, IDX_STAT}) begin
         r = s;
      end
      return r;
   endfunction

   // elaboration checks: fields and masks must fit the 16-bit word
   // and the 8-bit index that this bank decodes
   if (REG_W != 16) begin
      $error("register width must be 16");
   end
   if (IDX_W != 8) begin
      $error("index width must be 8");
   end
   if (ID_OUI_W + ID_MODEL_W + ID_REV_W != REG_W) begin
      $error("id low fields must fill the word");
   end
   if (ID_OUI_LSB != ID_MODEL_LSB + ID_MODEL_W) begin
      $error("oui field must sit above the model field");
   end
   if (ID_MODEL_LSB != ID_REV_LSB + ID_REV_W) begin
      $error("model field must sit above the revision field");
   end
   // advert bits 15:14 and 9 must never be writable or set at reset
   if ((ADV_RW_MASK & 16'hC200) != 16'h0000) begin
      $error("reserved advert bits in the write mask");
   end
   if ((ADV_RST & ~ADV_RW_MASK) != 16'h0000) begin
      $error("advert reset value outside the write mask");
   end
   // strap defaults land only on bits that software may also write
   if (!ADV_RW_MASK[ADV_SYM] || !ADV_RW_MASK[ADV_10FD] ||
       !ADV_RW_MASK[ADV_10HD]) begin
      $error("strap default bits must be writable");
   end
   // the synchroniser needs two edges before the capture reads it
   if (STRAP_SETTLE < 2'h2) begin
      $error("strap settle count below synchroniser depth");
   end
   if (STRAP_W != 4) begin
      $error("strap vector must hold four straps");
   end
   // status word must hold busy, captured and the strap levels
   if (STAT_STRAP + STRAP_W > REG_W || STAT_CAPT >= STAT_STRAP) begin
      $error("status fields overflow the word");
   end
   // index 8'hFF parks unmapped accesses, so no register may use it
   if (IDX_CTRL == 8'hFF || IDX_STAT == 8'hFF || IDX_ADV == 8'hFF) begin
      $error("index 8'hFF is kept for unmapped accesses");
   end
   if (IDX_ID_HIGH == IDX_ID_LOW || IDX_ID_LOW == IDX_ADV ||
       IDX_ADV == IDX_CTRL || IDX_CTRL == IDX_STAT) begin
      $error("register indices collide");
   end

   // word index of the current address phase, shared by both paths
   assign aidx = word_index(haddr);

   assign strap_pins[STRAP_AN]     = autoneg_pin_cfg;
   assign strap_pins[STRAP_SPEED]  = speed_pin_cfg;
   assign strap_pins[STRAP_DUPLEX] = duplex_pin_cfg;
   assign strap_pins[STRAP_MPAUSE] = manual_pause_pin_cfg;

   strap_capture u_strap (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .strap_pins (strap_pins),
      .sc         (ac.strap_src)
   );

   adv_loader u_loader (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .ee_rd_req   (ee_rd_req),
      .ee_rd_valid (ee_rd_valid),
      .ee_rd_data  (ee_rd_data),
      .lc          (ac.loader)
   );

   // latched strap levels, already synchronised and held
   assign an_s  = ac.strap_val[STRAP_AN];
   assign spd_s = ac.strap_val[STRAP_SPEED];
   assign dup_s = ac.strap_val[STRAP_DUPLEX];
   assign mp_s  = ac.strap_val[STRAP_MPAUSE];

   // status shows loader activity, capture state and the latched straps
   always_comb begin
      stat_word = ZERO_WORD;
      stat_word[STAT_BUSY] = ac.load_busy;
      stat_word[STAT_CAPT] = ac.captured;
      stat_word[STAT_STRAP +: STRAP_W] = ac.strap_val;
   end

   // bus front end: zero wait states, every transfer answered okay
   assign addr_take = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;
   assign wword     = hwdata[15:0];

   // address phase capture; hsize is not checked, every write is a word
   always_comb begin
      wr_pend_d = addr_take && hwrite;
      widx_d    = widx_q;
      if (addr_take) begin
         // unmapped accesses park on 8'hFF, which no register decodes
         widx_d = aidx[8] ? 8'hFF : aidx[7:0];
      end
   end

   // register next values; the loader overrides a same-cycle write
   always_comb begin
      idh_d    = idh_q;
      idl_d    = idl_q;
      adv_d    = adv_q;
      reload_d = 1'b0;
      if (wr_pend_q) begin
         case (widx_q)
            IDX_ID_HIGH: begin
               idh_d = wword;                          // R16
            end
            IDX_ID_LOW: begin
               idl_d[ID_OUI_LSB +: ID_OUI_W] =
                  wword[ID_OUI_LSB +: ID_OUI_W];       // R01
               idl_d[ID_MODEL_LSB +: ID_MODEL_W] =
                  wword[ID_MODEL_LSB +: ID_MODEL_W];   // R02
               idl_d[ID_REV_LSB +: ID_REV_W] =
                  wword[ID_REV_LSB +: ID_REV_W];       // R03
            end
            IDX_ADV: begin
               // bit 12 is stored as written; software keeps it 0
               adv_d = wword & ADV_RW_MASK;            // R17
            end
            IDX_CTRL: begin
               reload_d = wword[CTRL_RELOAD];          // R05
            end
            default: begin
               reload_d = 1'b0;                        // unmapped or status: ignored
            end
         endcase
      end
      if (ac.strap_done) begin
         adv_d[ADV_SYM]  = ~mp_s;                      // R09
         adv_d[ADV_10FD] = an_s | (~spd_s & dup_s);    // R12
         adv_d[ADV_10HD] = an_s | ~spd_s;              // R13
      end
      if (ac.load_valid) begin
         adv_d = ac.load_data & ADV_RW_MASK;           // R05 R10
      end
   end

   // the loader runs once the strap defaults are in, and on reload
   assign start_d       = ac.strap_done || reload_d;   // R05
   assign ac.load_start = start_q;

   // read data comes from the next values, so a read right after a
   // write to the same word already returns the new contents
   always_comb begin
      rdata_d = rdata_q;
      if (addr_take && !hwrite) begin
         rdata_d = {16'h0000,
                    read_word(aidx, idh_d, idl_d,
                              adv_d, stat_word)};      // R04
      end
   end

   // register state; advert bits 15:14 and 9 never hold a one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         widx_q    <= 8'hFF;
         idh_q     <= OUI_HIGH_ID;                     // R16
         idl_q     <= {OUI_LOW_ID, MODEL_ID, REV_ID};  // R01 R02 R03
         adv_q     <= ADV_RST;                         // R06 R08 R11 R14
         rdata_q   <= 32'h0000_0000;
         start_q   <= 1'b0;
      end else begin
         wr_pend_q <= wr_pend_d;
         widx_q    <= widx_d;
         idh_q     <= idh_d;
         idl_q     <= idl_d;
         adv_q     <= adv_d & ADV_RW_MASK;             // R17
         rdata_q   <= rdata_d;
         start_q   <= start_d;
      end
   end

   // word outputs toward the negotiation engine and management path
   assign advert_word  = adv_q;                        // R06 R08
   assign id_high_word = idh_q;
   assign id_low_word  = idl_q;
endmodule

// >>> bench/phy_regs_sva.sv
// port checker for the phy register bank
`timescale 1ns/10ps
module phy_regs_sva (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        ee_rd_req,
   input wire logic        ee_rd_valid,
   input wire logic [15:0] ee_rd_data,
   input wire logic [15:0] advert_word,
   input wire logic [15:0] id_high_word,
   input wire logic [15:0] id_low_word
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic tk;
   // address phase taken this edge
   assign tk = hsel & htrans[1] & hready;
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("bus not ready or not okay");
   property p_hi; hrdata[31:16] == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_rsvd; advert_word[15:14] == 2'b00 && !advert_word[9];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_rst; $rose(hresetn) |-> advert_word == 16'h0181; endproperty
   a_rst: assert property (p_rst) else $error("bad advert default");
   // loader must wait for straps, then fetch exactly at the sixth edge
   property p_fetch; $rose(hresetn) |-> !ee_rd_req [*5] ##1 ee_rd_req;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch timing");
   property p_hold; ee_rd_req && !ee_rd_valid |=> ee_rd_req; endproperty
   a_hold: assert property (p_hold) else $error("request dropped");
   property p_load;
      ee_rd_req && ee_rd_valid |-> ##2
         advert_word == ($past(ee_rd_data, 2) & 16'h3DFF);
   endproperty
   a_load: assert property (p_load) else $error("load mismatch");
   property p_idl;
      tk && hwrite && haddr == 32'h0000_000C |=> ##1
         id_low_word == $past(hwdata[15:0]);
   endproperty
   a_idl: assert property (p_idl) else $error("id low write");
   property p_idh;
      tk && hwrite && haddr == 32'h0000_0008 |=> ##1
         id_high_word == $past(hwdata[15:0]);
   endproperty
   a_idh: assert property (p_idh) else $error("id high write");
   property p_rdl;
      tk && !hwrite && haddr == 32'h0000_000C |=> hrdata[15:0] == id_low_word;
   endproperty
   a_rdl: assert property (p_rdl) else $error("id low read");
   c_reload: cover property (tk && hwrite && haddr == 32'h0000_0040);
   c_load: cover property (ee_rd_req && ee_rd_valid);
   c_rst: cover property ($rose(hresetn));
endmodule
bind phy_id_autoneg_advert_regs phy_regs_sva u_sva (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .ee_rd_req(ee_rd_req), .ee_rd_valid(ee_rd_valid),
   .ee_rd_data(ee_rd_data), .advert_word(advert_word),
   .id_high_word(id_high_word), .id_low_word(id_low_word));

// >>> bench/ee_model.sv
// eeprom side model answering one word per request
`timescale 1ns/10ps
module ee_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ee_rd_req,
   input  wire logic [15:0] word,
   input  wire logic [7:0]  lat,
   output logic             ee_rd_valid,
   output logic [15:0]      ee_rd_data
);
   logic [7:0] cnt_q;
   // data toggles outside the valid pulse, so a stale value differs from the last word only on every other cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 8'h00;
         ee_rd_valid <= 1'b0;
         ee_rd_data <= 16'h0000;
      end else if (ee_rd_req && !ee_rd_valid && cnt_q >= lat) begin
         cnt_q <= 8'h00;
         ee_rd_valid <= 1'b1;
         ee_rd_data <= word;
      end else begin
         cnt_q <= ee_rd_req ? cnt_q + 8'h01 : 8'h00;
         ee_rd_valid <= 1'b0;
         ee_rd_data <= ~ee_rd_data;
      end
   end
endmodule

// >>> bench/phy_id_autoneg_advert_regs_bench.sv
// self-checking bench for the phy register bank
`timescale 1ns/10ps
module phy_id_autoneg_advert_regs_bench;
   import phy_regs_pkg::*;
   localparam logic [15:0] ID_HI = 16'h0ABC; // arbitrary value
   localparam logic [5:0]  OUI_LO = 6'h0A; // arbitrary value
   localparam logic [5:0]  MODEL = 6'h11; // arbitrary value
   localparam logic [3:0]  REV = 4'h5; // arbitrary value
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [3:0]  straps = 4'h0;
   logic [15:0] word = 16'h0000;
   logic [7:0]  lat = 8'h00;
   logic [15:0] e;
   logic        hreadyout, hresp, ee_rd_req, ee_rd_valid;
   logic [31:0] hrdata;
   logic [15:0] ee_rd_data, advert_word, id_high_word, id_low_word;
   int          n_errors = 0;
   int          num_checks = 0;
   always #12.5 hclk = ~hclk;
   phy_id_autoneg_advert_regs #(.OUI_HIGH_ID(ID_HI), .OUI_LOW_ID(OUI_LO),
      .MODEL_ID(MODEL), .REV_ID(REV)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .autoneg_pin_cfg(straps[STRAP_AN]),
      .speed_pin_cfg(straps[STRAP_SPEED]),
      .duplex_pin_cfg(straps[STRAP_DUPLEX]),
      .manual_pause_pin_cfg(straps[STRAP_MPAUSE]),
      .ee_rd_req(ee_rd_req), .ee_rd_valid(ee_rd_valid),
      .ee_rd_data(ee_rd_data), .advert_word(advert_word),
      .id_high_word(id_high_word), .id_low_word(id_low_word));
   ee_model u_ee (.hclk(hclk), .hresetn(hresetn), .ee_rd_req(ee_rd_req),
      .word(word), .lat(lat), .ee_rd_valid(ee_rd_valid),
      .ee_rd_data(ee_rd_data));
   function automatic logic [31:0] ba(input logic [7:0] i);
      return {22'h0, i, 2'b00};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // one single transfer; called just after a rising edge
   task automatic bus(input logic [31:0] a, input logic w,
                      input logic [15:0] d, output logic [31:0] r);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= {16'h0000, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      logic [31:0] r;
      bus(a, 1'b1, d, r);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] x);
      logic [31:0] r;
      bus(a, 1'b0, 16'h0000, r);
      chk(r, x);
   endtask
   task automatic rst(input logic [3:0] s);
      hresetn <= 1'b0;
      straps <= s;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // watchdog; the run needs well under a thousand cycles
   initial begin
      #100_000;
      n_errors++;
      test_done;
   end
   initial begin
      lat <= 8'd40;
      // every strap combination, read before the slow loader answers
      for (int k = 0; k < 16; k++) begin
         rst(k[3:0]);
         rd(ba(IDX_ID_LOW), {16'h0, OUI_LO, MODEL, REV});
         rd(ba(IDX_ID_HIGH), {16'h0, ID_HI});
         repeat (4) @(posedge hclk);
         e = 16'h0181;
         e[10] = ~straps[3];
         e[6] = straps[0] | (~straps[1] & straps[2]);
         e[5] = straps[0] | ~straps[1];
         rd(ba(IDX_ADV), {16'h0, e});
         rd(ba(IDX_STAT), {24'h0, straps, 4'h3});
      end
      $display("test straps done");
      word <= 16'hFFFF;
      lat <= 8'd3;
      rst(4'h0);
      repeat (20) @(posedge hclk);
      rd(ba(IDX_ADV), 32'h0000_3DFF);
      rd(ba(IDX_STAT), 32'h0000_0002);
      $display("test loader done");
      wr(ba(IDX_ADV), 16'hEFFF);
      rd(ba(IDX_ADV), 32'h0000_2DFF);
      wr(ba(IDX_ADV), 16'h0000);
      rd(ba(IDX_ADV), 32'h0000_0000);
      wr(ba(IDX_ID_LOW), 16'hFFFF);
      rd(ba(IDX_ID_LOW), 32'h0000_FFFF);
      chk({16'h0, id_low_word}, 32'h0000_FFFF);
      wr(ba(IDX_ID_HIGH), 16'h1234);
      rd(ba(IDX_ID_HIGH), 32'h0000_1234);
      chk({16'h0, id_high_word}, 32'h0000_1234);
      rd(32'h0000_0014, 32'h0000_0000);
      $display("test access done");
      word <= 16'h0C21;
      wr(ba(IDX_CTRL), 16'h0001);
      repeat (20) @(posedge hclk);
      rd(ba(IDX_ADV), 32'h0000_0C21);
      chk({16'h0, advert_word}, 32'h0000_0C21);
      rd(ba(IDX_CTRL), 32'h0000_0000);
      $display("test reload done");
      test_done;
   end
endmodule
